// ===== logic/ccpf_top.sv
module ccpf_top (
	input  wire logic       CLOCK,
	input  wire logic       RST,
	input  wire logic       CE,
	input  wire logic [1:0] MODE_SEL,
	input  wire logic       ADDR_STRAP_BIT0,
	input  wire logic       ADDR_STRAP_BIT1,
	input  wire logic       CTRL_SERIAL_CLOCK,
	input  wire logic       CTRL_SELECT_N,
	input  wire logic       CTRL_SERIAL_IN,
	output logic            CTRL_SERIAL_OUT,
	output logic            CTRL_SERIAL_OUT_OE,
	input  wire logic       I2C_SCL,
	input  wire logic       I2C_SDA_IN,
	output logic            I2C_SDA_OUT,
	output logic            I2C_SDA_OE,
	input  wire logic       ADC_WORD_CLOCK,
	input  wire logic       DAC_WORD_CLOCK,
	input  wire logic [5:0] ADC_CLIP,
	input  wire logic [7:0] DAC_CH_ZERO,
	output logic            OVERFLOW_FLAG,
	output logic            ZERO_FLAG,
	output logic            PORTS_READY
);
	// ****************************************************************
	// Input synchronisers and edge detection
	// ****************************************************************
	typedef enum {I_IDLE, I_ADDR, I_ADDR_ACK, I_REG, I_REG_ACK, I_WDATA, I_WDATA_ACK, I_RDATA, I_RDATA_ACK}
		ccpf_i2c_type;

	logic [10:0] sync_q;
	logic        mc_s, sel_n_s, mdi_s, scl_s, sda_s, awc_s, dwc_s;
	logic [1:0]  mode_s, strap_s;
	logic        mc_d, sel_n_d, scl_d, sda_d, awc_d, dwc_d;

	ccpf_sync #(.WIDTH(11)) u_sync (
		.clock (CLOCK),
		.rst   (RST),
		.ce    (CE),
		.d     ({CTRL_SERIAL_CLOCK, CTRL_SELECT_N, CTRL_SERIAL_IN, I2C_SCL, I2C_SDA_IN, ADC_WORD_CLOCK,
		         DAC_WORD_CLOCK, MODE_SEL, ADDR_STRAP_BIT1, ADDR_STRAP_BIT0}),
		.q     (sync_q)
	);
	assign {mc_s, sel_n_s, mdi_s, scl_s, sda_s, awc_s, dwc_s, mode_s, strap_s} = sync_q;

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			{mc_d, scl_d, awc_d, dwc_d} <= 4'h0;
			{sel_n_d, sda_d}            <= 2'h3;
		end else if (CE) begin
			{mc_d, sel_n_d, scl_d, sda_d, awc_d, dwc_d} <= {mc_s, sel_n_s, scl_s, sda_s, awc_s, dwc_s};
		end
	end

	wire mc_rise  = mc_s & ~mc_d;
	wire mc_fall  = ~mc_s & mc_d;
	wire sel_rise = sel_n_s & ~sel_n_d;
	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	wire awc_rise = awc_s & ~awc_d;
	wire dwc_rise = dwc_s & ~dwc_d;

	// ****************************************************************
	// Reset completion pulse and mode capture
	// ****************************************************************
	logic        mode_taken;
	logic [1:0]  mode;
	logic [12:0] pulse_cnt;
	logic        pulse_active;

	// The synchroniser restarts from zero in reset, so the mode pins are read only once it has refilled.
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			mode_taken <= 1'b0;
			mode       <= 2'h1;
		end else if (CE && !mode_taken && pulse_cnt == ccpf_pkg::MODE_SAMPLE_AT) begin
			mode_taken <= 1'b1;
			mode       <= mode_s;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			pulse_cnt    <= 13'h0;
			pulse_active <= 1'b1;
			PORTS_READY  <= 1'b0;
		end else if (CE && pulse_active) begin
			pulse_cnt <= pulse_cnt + 13'h1;
			if (pulse_cnt == ccpf_pkg::DONE_PULSE_CYCLES - 13'h1) begin
				pulse_active <= 1'b0;
				PORTS_READY  <= 1'b1;
			end
		end
	end

	wire spi_en = PORTS_READY && mode == ccpf_pkg::MODE_FOUR_WIRE;
	wire i2c_en = PORTS_READY && mode == ccpf_pkg::MODE_TWO_WIRE;

	// ****************************************************************
	// Overflow and zero flags
	// ****************************************************************
	logic [7:0]  cfg;
	logic [10:0] ovf_cnt;
	logic [5:0]  ovf_status;
	logic [10:0] zero_cnt [8];
	logic [7:0]  zero_det;
	logic        ovf_clear;
	logic        zero_sel;

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ovf_cnt <= 11'h0;
		end else if (CE) begin
			if (|ADC_CLIP) begin
				ovf_cnt <= ccpf_pkg::WCLK_HOLD_COUNT;
			end else if (awc_rise && ovf_cnt != 11'h0) begin
				ovf_cnt <= ovf_cnt - 11'h1;
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ovf_status <= 6'h0;
		end else if (CE) begin
			ovf_status <= (ovf_status & ~{6{ovf_clear}}) | ADC_CLIP;
		end
	end

	for (genvar ch = 0; ch < 8; ch++) begin : g_zero
		always_ff @(posedge CLOCK) begin
			if (RST) begin
				zero_cnt[ch] <= 11'h0;
			end else if (CE && dwc_rise) begin
				if (!DAC_CH_ZERO[ch]) begin
					zero_cnt[ch] <= 11'h0;
				end else if (zero_cnt[ch] != ccpf_pkg::WCLK_HOLD_COUNT) begin
					zero_cnt[ch] <= zero_cnt[ch] + 11'h1;
				end
			end
		end
		assign zero_det[ch] = zero_cnt[ch] == ccpf_pkg::WCLK_HOLD_COUNT;
	end

	always_comb begin
		case (ccpf_pkg::ccpf_combine_type'(cfg[ccpf_pkg::CFG_ZERO_FLAG_COMBINE_SEL_LSB +: 3]))
			ccpf_pkg::ZC_AND8: zero_sel = &zero_det;
			ccpf_pkg::ZC_OR8:  zero_sel = |zero_det;
			ccpf_pkg::ZC_AND6: zero_sel = &zero_det[5:0];
			ccpf_pkg::ZC_OR6:  zero_sel = |zero_det[5:0];
			ccpf_pkg::ZC_AND2: zero_sel = &zero_det[1:0];
			ccpf_pkg::ZC_OR2:  zero_sel = |zero_det[1:0];
			default:           zero_sel = &zero_det;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			OVERFLOW_FLAG <= 1'b1;
			ZERO_FLAG     <= 1'b0;
		end else if (CE) begin
			// The completion pulse overrides polarity so it ends high-to-low unless an overflow is still being held.
			OVERFLOW_FLAG <= pulse_active | ((ovf_cnt != 11'h0) ^ cfg[ccpf_pkg::CFG_OVERFLOW_POLARITY_SEL_BIT]);
			ZERO_FLAG     <= zero_sel ^ cfg[ccpf_pkg::CFG_ZERO_FLAG_POLARITY_SEL_BIT];
		end
	end

	// ****************************************************************
	// Register access shared by both ports
	// ****************************************************************
	logic       wr_en;
	logic [6:0] wr_addr;
	logic [7:0] wr_data;
	logic [6:0] rd_addr;
	logic [6:0] rd_addr_q;
	logic [7:0] mem_rd;
	logic [7:0] read_byte;
	logic [6:0] spi_addr;
	logic [6:0] i2c_index;

	assign rd_addr = spi_en ? spi_addr : i2c_index;

	ccpf_regmem u_mem (
		.clock   (CLOCK),
		.ce      (CE),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.rd_addr (rd_addr),
		.rd_data (mem_rd)
	);

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			rd_addr_q <= ccpf_pkg::REG_FIRST;
		end else if (CE) begin
			rd_addr_q <= rd_addr;
		end
	end

	always_comb begin
		case (rd_addr_q)
			ccpf_pkg::REG_CONFIG:      read_byte = cfg;
			ccpf_pkg::REG_ZERO_STATUS: read_byte = zero_det;
			ccpf_pkg::REG_OVF_STATUS:  read_byte = {2'h0, ovf_status};
			default:                   read_byte = mem_rd;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			cfg <= ccpf_pkg::CONFIG_RESET;
		end else if (CE && wr_en && wr_addr == ccpf_pkg::REG_CONFIG) begin
			cfg <= wr_data;
		end
	end

	// ****************************************************************
	// Four-wire port
	// ****************************************************************
	logic [4:0] spi_cnt;
	logic [6:0] spi_shift;
	logic       spi_read;
	logic       spi_pending;
	logic [7:0] spi_data;
	logic [7:0] spi_out;
	logic       spi_wr;
	logic       spi_load;

	wire spi_rx  = spi_en && !sel_n_s && mc_rise;
	wire spi_tx  = spi_en && !sel_n_s && mc_fall;
	assign spi_load = spi_tx && spi_read && spi_cnt == 5'd8;
	assign spi_wr   = spi_en && spi_pending && ccpf_pkg::is_defined({1'b0, spi_addr})
		&& (sel_rise || (spi_rx && spi_cnt == 5'd23));

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			spi_cnt     <= 5'd0;
			spi_shift   <= 7'h0;
			spi_read    <= 1'b0;
			spi_pending <= 1'b0;
			spi_addr    <= ccpf_pkg::REG_FIRST;
			spi_data    <= 8'h00;
		end else if (CE) begin
			if (sel_n_s) begin
				spi_cnt     <= 5'd0;
				spi_pending <= 1'b0;
			end else if (spi_rx) begin
				spi_shift <= {spi_shift[5:0], mdi_s};
				spi_cnt   <= (spi_cnt == 5'd23) ? 5'd16 : spi_cnt + 5'd1;
				if (spi_cnt == 5'd7) begin
					spi_read <= spi_shift[6];
					spi_addr <= {spi_shift[5:0], mdi_s};
				end
				if (spi_cnt == 5'd15 || spi_cnt == 5'd23) begin
					spi_data    <= {spi_shift, mdi_s};
					spi_pending <= !spi_read;
				end
				if (spi_cnt == 5'd23) begin
					spi_addr <= spi_addr + 7'h01;
				end
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			spi_out            <= 8'h00;
			CTRL_SERIAL_OUT    <= 1'b0;
			CTRL_SERIAL_OUT_OE <= 1'b0;
		end else if (CE) begin
			if (sel_n_s || !spi_en) begin
				CTRL_SERIAL_OUT_OE <= 1'b0;
			end else if (spi_load) begin
				spi_out            <= {read_byte[6:0], 1'b0};
				CTRL_SERIAL_OUT    <= read_byte[7];
				CTRL_SERIAL_OUT_OE <= 1'b1;
			end else if (spi_tx && spi_cnt == 5'd16) begin
				CTRL_SERIAL_OUT_OE <= 1'b0;
			end else if (spi_tx && spi_read && spi_cnt > 5'd8 && spi_cnt < 5'd16) begin
				CTRL_SERIAL_OUT <= spi_out[7];
				spi_out         <= {spi_out[6:0], 1'b0};
			end
		end
	end

	// ****************************************************************
	// Two-wire port
	// ****************************************************************
	ccpf_i2c_type i2c_state;
	logic [3:0]   i2c_bits;
	logic [7:0]   i2c_shift;
	logic         i2c_rw;
	logic         i2c_master_ack;
	logic         i2c_wr;
	logic         i2c_load;

	wire i2c_start = i2c_en && scl_s && scl_d && sda_d && !sda_s;
	wire i2c_stop  = i2c_en && scl_s && scl_d && !sda_d && sda_s;
	wire addr_hit  = i2c_shift[7:1] == {ccpf_pkg::SLAVE_ADDR_FIXED, strap_s[1], strap_s[0]};
	wire idx_ok    = ccpf_pkg::is_defined(i2c_shift);
	wire byte_end  = i2c_en && scl_fall && i2c_bits == 4'd8;
	assign i2c_wr   = byte_end && i2c_state == I_WDATA && ccpf_pkg::is_defined({1'b0, i2c_index});
	assign i2c_load = i2c_en && scl_fall && ((i2c_state == I_ADDR_ACK && i2c_rw)
		|| (i2c_state == I_RDATA_ACK && i2c_master_ack));

	always_comb begin
		wr_en   = spi_wr | i2c_wr;
		wr_addr = spi_en ? spi_addr : i2c_index;
		wr_data = spi_en ? spi_data : i2c_shift;
	end

	assign ovf_clear = (spi_load || i2c_load) && rd_addr_q == ccpf_pkg::REG_OVF_STATUS;

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			i2c_state      <= I_IDLE;
			i2c_bits       <= 4'd0;
			i2c_shift      <= 8'h00;
			i2c_rw         <= 1'b0;
			i2c_master_ack <= 1'b0;
			i2c_index      <= ccpf_pkg::REG_FIRST;
			I2C_SDA_OUT    <= 1'b0;
			I2C_SDA_OE     <= 1'b0;
		end else if (CE) begin
			if (!i2c_en || i2c_stop) begin
				i2c_state  <= I_IDLE;
				I2C_SDA_OE <= 1'b0;
			end else if (i2c_start) begin
				// A repeated start lands here too, keeping the index for the read.
				i2c_state  <= I_ADDR;
				i2c_bits   <= 4'd0;
				I2C_SDA_OE <= 1'b0;
			end else if (scl_rise) begin
				if (i2c_state == I_RDATA_ACK) begin
					i2c_master_ack <= !sda_s;
					if (!sda_s) begin
						i2c_index <= ccpf_pkg::next_index(i2c_index);
					end
				end else if (i2c_state inside {I_ADDR, I_REG, I_WDATA} && i2c_bits != 4'd8) begin
					i2c_shift <= {i2c_shift[6:0], sda_s};
					i2c_bits  <= i2c_bits + 4'd1;
				end
			end else if (scl_fall) begin
				case (i2c_state)
					I_ADDR, I_REG, I_WDATA: begin
						if (i2c_bits == 4'd8) begin
							i2c_bits <= 4'd0;
							case (i2c_state)
								I_ADDR: begin
									i2c_rw     <= i2c_shift[0];
									I2C_SDA_OE <= addr_hit;
									i2c_state  <= addr_hit ? I_ADDR_ACK : I_IDLE;
								end
								I_REG: begin
									I2C_SDA_OE <= idx_ok;
									i2c_state  <= idx_ok ? I_REG_ACK : I_IDLE;
									if (idx_ok) begin
										i2c_index <= i2c_shift[6:0];
									end
								end
								default: begin
									I2C_SDA_OE <= i2c_wr;
									i2c_state  <= i2c_wr ? I_WDATA_ACK : I_IDLE;
									if (i2c_wr) begin
										i2c_index <= ccpf_pkg::next_index(i2c_index);
									end
								end
							endcase
						end
					end
					I_ADDR_ACK, I_RDATA_ACK: begin
						if (i2c_load) begin
							i2c_state   <= I_RDATA;
							i2c_shift   <= {read_byte[6:0], 1'b0};
							I2C_SDA_OE  <= !read_byte[7];
							i2c_bits    <= 4'd1;
						end else begin
							I2C_SDA_OE <= 1'b0;
							i2c_state  <= (i2c_state == I_ADDR_ACK) ? I_REG : I_IDLE;
							i2c_bits   <= 4'd0;
						end
					end
					I_REG_ACK, I_WDATA_ACK: begin
						I2C_SDA_OE <= 1'b0;
						i2c_state  <= I_WDATA;
					end
					I_RDATA: begin
						if (i2c_bits == 4'd8) begin
							I2C_SDA_OE <= 1'b0;
							i2c_state  <= I_RDATA_ACK;
						end else begin
							I2C_SDA_OE <= !i2c_shift[7];
							i2c_shift  <= {i2c_shift[6:0], 1'b0};
							i2c_bits   <= i2c_bits + 4'd1;
						end
					end
					default: i2c_state <= I_IDLE;
				endcase
			end
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_spi_release: assert property (@(posedge CLOCK) disable iff (RST || !CE)
		sel_n_s && $past(sel_n_s) |-> !CTRL_SERIAL_OUT_OE) else $error("four-wire output driven while deselected");
	a_ovf_sticky: assert property (@(posedge CLOCK) disable iff (RST || !CE)
		ADC_CLIP[0] |=> ovf_status[0]) else $error("overflow status bit not set");
	a_ovf_pin_on: assert property (@(posedge CLOCK) disable iff (RST || !CE)
		(|ADC_CLIP) && !pulse_active ##1 CE |=> OVERFLOW_FLAG != cfg[0]) else $error("overflow pin not active");
	a_done_pulse_len: assert property (@(posedge CLOCK) disable iff (RST)
		$fell(pulse_active) |-> $past(pulse_cnt) == 13'h0fff) else $error("completion pulse length wrong");
	a_ports_gated: assert property (@(posedge CLOCK) disable iff (RST)
		pulse_active |-> !wr_en && !I2C_SDA_OE && !CTRL_SERIAL_OUT_OE) else $error("port active before completion");
	a_index_wrap: assert property (@(posedge CLOCK) disable iff (RST || !CE)
		i2c_wr && i2c_index == 7'h5e |=> i2c_index == 7'h40) else $error("index did not wrap");
	a_undef_nack: assert property (@(posedge CLOCK) disable iff (RST || !CE)
		i2c_en && scl_fall && i2c_state == I_REG && i2c_bits == 4'd8 && !idx_ok |=> !I2C_SDA_OE)
		else $error("acknowledge given for undefined register");
	a_addr_match: assert property (@(posedge CLOCK) disable iff (RST || !CE)
		i2c_en && scl_fall && i2c_state == I_ADDR && i2c_bits == 4'd8 && !addr_hit |=> i2c_state == I_IDLE && !I2C_SDA_OE)
		else $error("foreign slave address acknowledged");
	a_spi_latch: assert property (@(posedge CLOCK) disable iff (RST || !CE)
		spi_en && sel_rise && spi_pending && spi_addr == ccpf_pkg::REG_CONFIG |=> cfg == $past(spi_data))
		else $error("write not latched at select rise");
endmodule // ccpf_top

// ===== logic/ccpf_pkg.sv
package ccpf_pkg;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [6:0] REG_FIRST       = 7'h40;
	localparam logic [6:0] REG_LAST        = 7'h5e;
	localparam logic [6:0] REG_CONFIG      = 7'h5a;
	localparam logic [6:0] REG_ZERO_STATUS = 7'h5c;
	localparam logic [6:0] REG_OVF_STATUS  = 7'h5d;
	localparam logic [7:0] CONFIG_RESET    = 8'h00;
	localparam int         CFG_OVERFLOW_POLARITY_SEL_BIT    = 0;
	localparam int         CFG_ZERO_FLAG_POLARITY_SEL_BIT    = 1;
	localparam int         CFG_ZERO_FLAG_COMBINE_SEL_LSB    = 2;
	localparam int         MEM_DEPTH       = 31;

	// ****************************************************************
	// Timing and addressing
	// ****************************************************************
	localparam logic [10:0] WCLK_HOLD_COUNT   = 11'h400;
	localparam logic [12:0] DONE_PULSE_CYCLES = 13'h1000;
	localparam logic [12:0] MODE_SAMPLE_AT    = 13'h0002;
	localparam logic [4:0]  SLAVE_ADDR_FIXED  = 5'h11;
	localparam logic [1:0]  MODE_TWO_WIRE     = 2'h0;
	localparam logic [1:0]  MODE_FOUR_WIRE    = 2'h3;

	typedef enum logic [2:0] {
		ZC_AND8, ZC_OR8, ZC_AND6, ZC_OR6, ZC_AND2, ZC_OR2
	} ccpf_combine_type;

	function automatic logic is_defined(input logic [7:0] addr);
		is_defined = (addr >= {1'b0, REG_FIRST}) && (addr <= {1'b0, REG_LAST});
	endfunction

	function automatic logic [6:0] next_index(input logic [6:0] idx);
		next_index = (idx == REG_LAST) ? REG_FIRST : idx + 7'h01;
	endfunction
endpackage

// ===== logic/ccpf_sync.sv
module ccpf_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] stage;

	always_ff @(posedge clock) begin
		if (rst) begin
			stage <= '0;
			q     <= '0;
		end else if (ce) begin
			stage <= d;
			q     <= stage;
		end
	end
endmodule // ccpf_sync

// ===== logic/ccpf_regmem.sv
module ccpf_regmem (
	input  wire logic       clock,
	input  wire logic       ce,
	input  wire logic       wr_en,
	input  wire logic [6:0] wr_addr,
	input  wire logic [7:0] wr_data,
	input  wire logic [6:0] rd_addr,
	output logic      [7:0] rd_data
);
	logic [7:0] mem [ccpf_pkg::MEM_DEPTH];
	logic [6:0] wr_slot;
	logic [6:0] rd_slot;

	assign wr_slot = wr_addr - ccpf_pkg::REG_FIRST;
	assign rd_slot = rd_addr - ccpf_pkg::REG_FIRST;

	// Plain storage has no reset; software sets what it relies on.
	always_ff @(posedge clock) begin
		if (ce && wr_en) begin
			mem[wr_slot[4:0]] <= wr_data;
		end
	end

	always_ff @(posedge clock) begin
		if (ce) begin
			rd_data <= (rd_slot[4:0] < 5'd31) ? mem[rd_slot[4:0]] : 8'h00;
		end
	end
endmodule // ccpf_regmem

// ===== tb/ccpf_host.sv
// ****************************************************************
// Host side of both serial control ports
// ****************************************************************
module ccpf_host (
	input  wire logic clk,
	input  wire logic sout,
	input  wire logic sout_oe,
	input  wire logic sda_oe,
	output logic      sck,
	output logic      sel_n,
	output logic      sin,
	output logic      scl,
	output logic      sda
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pull = 1'b0;
	wire  ctrl_serial_out  = sout_oe ? sout : 1'bz;
	// The two-wire data line has a pull-up, so it is high unless someone pulls it.
	assign sda = !(pull || sda_oe);
	initial begin
		sck = 1'b0;
		sel_n = 1'b1;
		sin = 1'b0;
		scl = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Data is set while the clock is low and read one edge after it rises.
	task automatic spi(input logic [23:0] word, input int nb, output logic [7:0] rd);
		sel_n <= 1'b0;
		w(4);
		for (int i = 0; i < nb; i++) begin
			sin <= word[23 - i];
			w(4);
			sck <= 1'b1;
			w(1);
			rd = {rd[6:0], ctrl_serial_out};
			w(3);
			sck <= 1'b0;
		end
		w(4);
		sel_n <= 1'b1;
		sin <= ~sin;
		w(8);
	endtask
	// Also used as repeated start; the long first wait lets an acknowledge drain.
	task automatic i2c_start();
		pull <= 1'b0;
		w(6);
		scl <= 1'b1;
		w(4);
		pull <= 1'b1;
		w(4);
		scl <= 1'b0;
		w(4);
	endtask
	task automatic i2c_stop();
		pull <= 1'b1;
		w(4);
		scl <= 1'b1;
		w(4);
		pull <= 1'b0;
		w(4);
	endtask
	// Eight bits MSB first, then a released acknowledge slot, which is a NACK on reads.
	task automatic i2c_byte(input logic [7:0] b, output logic [7:0] rd, output logic ack);
		logic [8:0] sh;
		sh = {b, 1'b1};
		for (int i = 0; i < 9; i++) begin
			pull <= ~sh[8];
			sh = sh << 1;
			w(4);
			scl <= 1'b1;
			w(2);
			if (i < 8) rd = {rd[6:0], sda};
			else ack = ~sda;
			w(2);
			scl <= 1'b0;
		end
	endtask
endmodule // ccpf_host

// ===== tb/ccpf_top_test.sv
module ccpf_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clock = 1'b0;
	logic       rst = 1'b1;
	logic [1:0] mode_sel = 2'h3;
	logic       strap0 = 1'b0;
	logic       strap1 = 1'b1;
	logic [2:0] wdiv = 3'h0;
	logic       adc_wclk = 1'b0;
	logic       dac_wclk = 1'b0;
	logic [5:0] adc_clip = 6'h00;
	logic [7:0] dac_zero = 8'hff;
	logic [7:0] rd;
	logic       ack;
	int         num_errors = 0;
	int         checks = 0;
	wire        sout, sout_oe, sda_oe, sda_out, ovf, zero, ready, sck, sel_n, sin, scl, sda;
	always #50 clock = ~clock;
	// Both word clocks run at one eighth of the system clock.
	always @(posedge clock) begin
		wdiv <= wdiv + 3'h1;
		adc_wclk <= wdiv[2];
		dac_wclk <= wdiv[2];
	end
	ccpf_top dut (.CLOCK(clock), .RST(rst), .CE(1'b1), .MODE_SEL(mode_sel), .ADDR_STRAP_BIT0(strap0),
		.ADDR_STRAP_BIT1(strap1), .CTRL_SERIAL_CLOCK(sck), .CTRL_SELECT_N(sel_n), .CTRL_SERIAL_IN(sin),
		.CTRL_SERIAL_OUT(sout), .CTRL_SERIAL_OUT_OE(sout_oe), .I2C_SCL(scl), .I2C_SDA_IN(sda),
		.I2C_SDA_OUT(sda_out), .I2C_SDA_OE(sda_oe), .ADC_WORD_CLOCK(adc_wclk), .DAC_WORD_CLOCK(dac_wclk),
		.ADC_CLIP(adc_clip), .DAC_CH_ZERO(dac_zero), .OVERFLOW_FLAG(ovf), .ZERO_FLAG(zero),
		.PORTS_READY(ready));
	ccpf_host host (.clk(clock), .sout(sout), .sout_oe(sout_oe), .sda_oe(sda_oe), .sck(sck),
		.sel_n(sel_n), .sin(sin), .scl(scl), .sda(sda));
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host.spi({1'b0, a, d, 8'h00}, 16, rd);
	endtask
	task automatic rdc(input logic [6:0] a, input logic [7:0] e, input string what);
		host.spi({1'b1, a, 16'h0000}, 16, rd);
		cmp(rd, e, what);
	endtask
	task automatic do_reset(input logic [1:0] mode);
		mode_sel <= mode;
		rst <= 1'b1;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		repeat (4090) @(posedge clock);
		cmp({7'h00, ovf}, 8'h01, "completion pulse");
		cmp({7'h00, ready}, 8'h00, "early ready");
		repeat (10) @(posedge clock);
		cmp({7'h00, ovf}, 8'h00, "pulse end");
		cmp({7'h00, ready}, 8'h01, "ready");
	endtask
	task automatic report_and_stop();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_spi();
		host.spi({1'b0, 7'h40, 16'h1122}, 24, rd);
		rdc(7'h40, 8'h11, "burst first");
		rdc(7'h41, 8'h22, "burst second");
		cmp({7'h00, sout_oe}, 8'h00, "output released");
	endtask
	task automatic t_flags();
		logic [5:0] exp;
		exp = 6'b111010;
		adc_clip <= 6'h20;
		@(posedge clock);
		adc_clip <= 6'h00;
		repeat (8000) @(posedge clock);
		cmp({7'h00, ovf}, 8'h01, "overflow held");
		repeat (400) @(posedge clock);
		cmp({7'h00, ovf}, 8'h00, "overflow over");
		cmp({7'h00, zero}, 8'h01, "all zero");
		rdc(7'h5d, 8'h20, "overflow status");
		rdc(7'h5d, 8'h00, "status cleared");
		wr(7'h5a, 8'h01);
		cmp({7'h00, ovf}, 8'h01, "overflow idle inverted");
		dac_zero <= 8'h03;
		repeat (20) @(posedge clock);
		rdc(7'h5c, 8'h03, "zero status");
		for (int m = 0; m < 6; m++) begin
			wr(7'h5a, {3'h0, m[2:0], 2'h0});
			cmp({7'h00, zero}, {7'h00, exp[m]}, "combine");
		end
		wr(7'h5a, 8'h12);
		cmp({7'h00, zero}, 8'h00, "zero inverted");
	endtask
	task automatic t_i2c();
		do_reset(2'h0);
		rdc(7'h5a, 8'hzz, "four-wire off in two-wire mode");
		host.i2c_start();
		host.i2c_byte(8'h8e, rd, ack);
		cmp({7'h00, ack}, 8'h00, "foreign address");
		host.i2c_stop();
		host.i2c_start();
		host.i2c_byte(8'h8c, rd, ack);
		cmp({7'h00, ack}, 8'h01, "own address");
		cmp({7'h00, sda_out}, 8'h00, "open drain level");
		host.i2c_byte(8'h5e, rd, ack);
		host.i2c_byte(8'ha5, rd, ack);
		cmp({7'h00, ack}, 8'h01, "data");
		host.i2c_byte(8'h3c, rd, ack);
		cmp({7'h00, ack}, 8'h01, "wrapped data");
		host.i2c_stop();
		for (int k = 0; k < 2; k++) begin
			host.i2c_start();
			host.i2c_byte(8'h8c, rd, ack);
			host.i2c_byte(k ? 8'h40 : 8'h5e, rd, ack);
			host.i2c_start();
			host.i2c_byte(8'h8d, rd, ack);
			host.i2c_byte(8'hff, rd, ack);
			cmp(rd, k ? 8'h3c : 8'ha5, "read back");
			host.i2c_stop();
		end
		host.i2c_start();
		host.i2c_byte(8'h8c, rd, ack);
		host.i2c_byte(8'h10, rd, ack);
		cmp({7'h00, ack}, 8'h00, "undefined index");
		host.i2c_stop();
	endtask
	initial begin
		do_reset(2'h3);
		t_spi();
		t_flags();
		t_i2c();
		report_and_stop();
	end
	initial begin
		repeat (40000) @(posedge clock);
		num_errors++;
		$display("ERROR at %0t: watchdog expired", $time);
		report_and_stop();
	end
endmodule // ccpf_top_test
